// File: lpc_pkg.sv
// constants for the line-locked pixel clock generator
// Behaviour
// (RULE1) the outside world supplies a master clock meant to run at 14.31818 MHz
// (RULE2) internal clock is master clock times analog divider, divider resets to eight
// (RULE3) host keeps master clock times divider below 120 MHz
// (RULE4) oscillator adds a programmable increment each clock; optional output divide by two
// (RULE5) divided oscillator clock drives a line-length counter whose wrap feeds the detector
// (RULE6) detector's other input is horizontal sync with selectable active polarity
// (RULE7) optional noise gates accept sync only after a programmable number of cycles
// (RULE8) detector error is filtered by proportional plus accumulating integral paths
// (RULE9) both gains have eight settings; larger setting means larger gain
// (RULE10) lock pin is driven with hysteresis set by a programmable threshold
// (RULE11) filtered error is added to nominal increment to form the live increment
// (RULE12) host can read the live increment
// (RULE13) detector off forces live increment equal to nominal increment
// (RULE14) hold pin keeps the live increment at its present value
// (RULE15) hold pin stops the detector updating on sync edges
// (RULE16) sampling clock phase is set in 31 even steps over one period; with the oscillator divide by two on, the steps cover only half a period
// (RULE17) source select routes the external clock to sampling, without phase shift
// (RULE18) data clock runs at sample rate or half, rising edge mid data
// (RULE19) with external clock selected the data clock comes from it
// (RULE20) copy output is the sample clock, optionally halved and inverted
// (RULE21) synth output always comes from the oscillator, optionally halved and inverted
// (RULE22) one error sample per valid sync edge, measured against the counter wrap
// (RULE23) noise gate counters run on the internal clock and restart when sync goes inactive
package lpc_pkg;
    // register offsets
    localparam logic [7:0] LPC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] LPC_OFS_NOMINC  = 8'h04;
    localparam logic [7:0] LPC_OFS_LINELEN = 8'h08;
    localparam logic [7:0] LPC_OFS_GAINS   = 8'h0C;
    localparam logic [7:0] LPC_OFS_GATES   = 8'h10;
    localparam logic [7:0] LPC_OFS_LOCKTHR = 8'h14;
    localparam logic [7:0] LPC_OFS_PHASE   = 8'h18;
    localparam logic [7:0] LPC_OFS_ADIV    = 8'h1C;
    localparam logic [7:0] LPC_OFS_LIVEINC = 8'h20;
    localparam logic [7:0] LPC_OFS_STATUS  = 8'h24;
    // control bit positions
    localparam int LPC_CB_DET_OFF   = 0;
    localparam int LPC_CB_HPOL      = 1;
    localparam int LPC_CB_DTO_DIV2  = 2;
    localparam int LPC_CB_EXT_SEL   = 3;
    localparam int LPC_CB_FMT_HALF  = 4;
    localparam int LPC_CB_COPY_DIV2 = 5;
    localparam int LPC_CB_COPY_INV  = 6;
    localparam int LPC_CB_SYN_DIV2  = 7;
    localparam int LPC_CB_SYN_INV   = 8;
    localparam int LPC_CB_HGATE_EN  = 9;
    localparam int LPC_CB_VGATE_EN  = 10;
    localparam int LPC_CTRL_W       = 11;
    // gain and gate field positions
    localparam int LPC_KP_LSB = 0;
    localparam int LPC_KI_LSB = 4;
    localparam int LPC_HG_LSB = 0;
    localparam int LPC_VG_LSB = 8;
    // reset values
    localparam logic [10:0] LPC_CTRL_RST    = 11'h002;
    localparam logic [31:0] LPC_NOMINC_RST  = 32'h2000_0000;
    localparam logic [11:0] LPC_LINELEN_RST = 12'h320;
    localparam logic [7:0]  LPC_ADIV_RST    = 8'h08;
    // one phase step is a 31st of the accumulator range
    localparam logic [31:0] LPC_PHASE_STEP  = 32'h0842_1084;
    localparam logic [4:0]  LPC_PHASE_MAX   = 5'h1E;
endpackage : lpc_pkg

// File: lpc_top.sv
// line-locked pixel clock generator: oscillator, detector, loop filter, clock outputs
`timescale 1ns/1ps
module lpc_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // sync, hold and external clock pins
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic        error_hold_pin,
    input  wire logic        external_sample_clock_in,
    // status and analog control
    output logic             lock_out,
    output logic             vsync_valid,
    output logic      [7:0]  analog_feedback_divider,
    // clock outputs
    output logic             internal_sample_clock,
    output logic             output_data_clock,
    output logic             sample_clock_copy_out,
    output logic             synth_clock_out
);
    typedef struct packed {
        logic [10:0]        ctrl;
        logic [31:0]        nominal_increment;
        logic [11:0]        line_len;
        logic [2:0]         kp;
        logic [2:0]         ki;
        logic [7:0]         hgate_len;
        logic [7:0]         vgate_len;
        logic [15:0]        lock_thr;
        logic [4:0]         phase_sel;
        logic [7:0]         analog_div;
        logic [31:0]        rdata;
        logic               hs1;
        logic               hs2;
        logic               vs1;
        logic               vs2;
        logic               fz1;
        logic               fz2;
        logic               ex1;
        logic               ex2;
        logic [7:0]         hcnt;
        logic [7:0]         vcnt;
        logic               hvalid;
        logic               vvalid;
        logic [31:0]        acc;
        logic               raw_prev;
        logic               div_clk;
        logic               sh_prev;
        logic               sh_div;
        logic               pll_prev;
        logic [11:0]        pix_cnt;
        logic signed [15:0] err;
        logic signed [31:0] integ;
        logic [31:0]        live_inc;
        logic               lock;
        logic               samp_clk;
        logic               samp_half;
        logic               data_clk;
        logic               copy_clk;
        logic               syn_half;
        logic               syn_clk;
    } lpc_state_t;

    lpc_state_t state_reg;
    lpc_state_t state_next;

    // decoded helpers, visible to the checks below
    logic               h_act;
    logic               v_act;
    logic               h_edge;
    logic               det_take;
    logic               pll_clk;
    logic               pll_rise;
    logic               sh_raw;
    logic               sh_clk;
    logic               samp;
    logic               samp_rise;
    logic               copy_base;
    logic               syn_base;
    logic [31:0]        sh_acc;
    logic signed [15:0] err_new;
    logic [15:0]        err_abs;
    logic signed [31:0] err_ext;
    logic signed [31:0] prop;
    logic signed [31:0] integ_new;

    always_comb begin
        state_next = state_reg;
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                lpc_pkg::LPC_OFS_CTRL:    state_next.ctrl = reg_wdata[10:0];
                lpc_pkg::LPC_OFS_NOMINC:  state_next.nominal_increment = reg_wdata;
                lpc_pkg::LPC_OFS_LINELEN: state_next.line_len = reg_wdata[11:0];
                lpc_pkg::LPC_OFS_GAINS: begin
                    state_next.kp = reg_wdata[lpc_pkg::LPC_KP_LSB +: 3];
                    state_next.ki = reg_wdata[lpc_pkg::LPC_KI_LSB +: 3];
                end
                lpc_pkg::LPC_OFS_GATES: begin
                    state_next.hgate_len = reg_wdata[lpc_pkg::LPC_HG_LSB +: 8];
                    state_next.vgate_len = reg_wdata[lpc_pkg::LPC_VG_LSB +: 8];
                end
                lpc_pkg::LPC_OFS_LOCKTHR: state_next.lock_thr = reg_wdata[15:0];
                lpc_pkg::LPC_OFS_PHASE: begin
                    // values past the last step are clipped to keep 31 even steps
                    if (reg_wdata[4:0] > lpc_pkg::LPC_PHASE_MAX) begin
                        state_next.phase_sel = lpc_pkg::LPC_PHASE_MAX;
                    end else begin
                        state_next.phase_sel = reg_wdata[4:0];
                    end
                end
                lpc_pkg::LPC_OFS_ADIV:    state_next.analog_div = reg_wdata[7:0]; // RULE2
                default: ;
            endcase
        end
        // register reads, data valid in the following cycle only
        state_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                lpc_pkg::LPC_OFS_CTRL:    state_next.rdata = {21'h0_0000, state_reg.ctrl};
                lpc_pkg::LPC_OFS_NOMINC:  state_next.rdata = state_reg.nominal_increment;
                lpc_pkg::LPC_OFS_LINELEN: state_next.rdata = {20'h00000, state_reg.line_len};
                lpc_pkg::LPC_OFS_GAINS:
                    state_next.rdata = {25'h00_0000, state_reg.ki, 1'b0, state_reg.kp};
                lpc_pkg::LPC_OFS_GATES:
                    state_next.rdata = {16'h0000, state_reg.vgate_len, state_reg.hgate_len};
                lpc_pkg::LPC_OFS_LOCKTHR: state_next.rdata = {16'h0000, state_reg.lock_thr};
                lpc_pkg::LPC_OFS_PHASE:   state_next.rdata = {27'h00_0000, state_reg.phase_sel};
                lpc_pkg::LPC_OFS_ADIV:    state_next.rdata = {24'h000000, state_reg.analog_div};
                lpc_pkg::LPC_OFS_LIVEINC: state_next.rdata = state_reg.live_inc; // RULE12
                lpc_pkg::LPC_OFS_STATUS:
                    state_next.rdata = {state_reg.err, 12'h000, state_reg.fz2,
                                        state_reg.vvalid, state_reg.hvalid, state_reg.lock};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end

        // pin synchronisers, first stage feeds only the second
        state_next.hs1 = hsync_in;
        state_next.hs2 = state_reg.hs1;
        state_next.vs1 = vsync_in;
        state_next.vs2 = state_reg.vs1;
        state_next.fz1 = error_hold_pin;
        state_next.fz2 = state_reg.fz1;
        state_next.ex1 = external_sample_clock_in;
        state_next.ex2 = state_reg.ex1;

        // sync noise gates
        h_act = state_reg.ctrl[lpc_pkg::LPC_CB_HPOL] ? state_reg.hs2 : ~state_reg.hs2; // RULE6
        v_act = state_reg.ctrl[lpc_pkg::LPC_CB_HPOL] ? state_reg.vs2 : ~state_reg.vs2;
        if (!h_act) begin
            state_next.hcnt   = 8'h00; // RULE23
            state_next.hvalid = 1'b0;
        end else if (!state_reg.ctrl[lpc_pkg::LPC_CB_HGATE_EN] ||
                     state_reg.hcnt >= state_reg.hgate_len) begin
            state_next.hvalid = 1'b1; // RULE7
        end else begin
            state_next.hcnt = state_reg.hcnt + 8'h01;
        end
        if (!v_act) begin
            state_next.vcnt   = 8'h00; // RULE23
            state_next.vvalid = 1'b0;
        end else if (!state_reg.ctrl[lpc_pkg::LPC_CB_VGATE_EN] ||
                     state_reg.vcnt >= state_reg.vgate_len) begin
            state_next.vvalid = 1'b1; // RULE7
        end else begin
            state_next.vcnt = state_reg.vcnt + 8'h01;
        end
        h_edge = state_next.hvalid & ~state_reg.hvalid;

        // oscillator and optional divide by two
        state_next.acc      = state_reg.acc + state_reg.live_inc; // RULE4
        state_next.raw_prev = state_reg.acc[31];
        if (state_reg.acc[31] && !state_reg.raw_prev) begin
            state_next.div_clk = ~state_reg.div_clk;
        end
        pll_clk = state_reg.ctrl[lpc_pkg::LPC_CB_DTO_DIV2] ? state_reg.div_clk
                                                            : state_reg.raw_prev;
        // phase shifter: offset the accumulator by whole 31st steps
        sh_acc = state_reg.acc + 32'(state_reg.phase_sel * lpc_pkg::LPC_PHASE_STEP); // RULE16
        sh_raw = sh_acc[31];
        state_next.sh_prev = sh_raw;
        if (sh_raw && !state_reg.sh_prev) begin
            state_next.sh_div = ~state_reg.sh_div;
        end
        sh_clk = state_reg.ctrl[lpc_pkg::LPC_CB_DTO_DIV2] ? state_reg.sh_div
                                                           : state_reg.sh_prev;

        // line-length feedback counter
        state_next.pll_prev = pll_clk;
        pll_rise = pll_clk & ~state_reg.pll_prev;
        if (pll_rise) begin
            if (state_reg.pix_cnt >= state_reg.line_len - 12'h001) begin
                state_next.pix_cnt = 12'h000; // RULE5
            end else begin
                state_next.pix_cnt = state_reg.pix_cnt + 12'h001;
            end
        end

        // detector: sign says which way the edge missed the wrap
        if (state_reg.pix_cnt < (state_reg.line_len >> 1)) begin
            err_new = -$signed({4'h0, state_reg.pix_cnt}); // RULE22
        end else begin
            err_new = $signed({4'h0, state_reg.line_len - state_reg.pix_cnt});
        end
        err_abs = err_new[15] ? 16'(-err_new) : err_new;
        det_take = h_edge && !state_reg.fz2 && !state_reg.ctrl[lpc_pkg::LPC_CB_DET_OFF]; // RULE15
        if (det_take) begin
            state_next.err = err_new; // RULE8
            if (err_abs <= state_reg.lock_thr) begin
                state_next.lock = 1'b1; // RULE10
            end else if ({1'b0, err_abs} > {state_reg.lock_thr, 1'b0}) begin
                state_next.lock = 1'b0;
            end
        end

        // loop filter: gain settings are shifts, so each step doubles the gain
        err_ext   = {{16{state_next.err[15]}}, state_next.err};
        prop      = err_ext <<< state_reg.kp; // RULE9
        integ_new = state_reg.integ + (err_ext <<< state_reg.ki);
        if (state_reg.ctrl[lpc_pkg::LPC_CB_DET_OFF]) begin
            state_next.err      = 16'sh0000;
            state_next.integ    = 32'sh0000_0000;
            state_next.lock     = 1'b0;
            state_next.live_inc = state_reg.nominal_increment; // RULE13
        end else if (state_reg.fz2) begin
            state_next.live_inc = state_reg.live_inc; // RULE14
        end else begin
            if (det_take) begin
                state_next.integ = integ_new; // RULE8
            end
            state_next.live_inc = state_reg.nominal_increment + 32'(prop + state_next.integ); // RULE11
        end

        // sampling clock source; external clock is only resolved to one clk period, 5 ns
        samp = state_reg.ctrl[lpc_pkg::LPC_CB_EXT_SEL] ? state_reg.ex2 : sh_clk; // RULE17
        state_next.samp_clk = samp;
        samp_rise = samp & ~state_reg.samp_clk;
        if (samp_rise) begin
            state_next.samp_half = ~state_reg.samp_half;
        end
        // data clock inverted so its rising edge sits half a period into the data
        state_next.data_clk = state_reg.ctrl[lpc_pkg::LPC_CB_FMT_HALF] ?
                              ~state_reg.samp_half : ~state_reg.samp_clk; // RULE18 RULE19
        copy_base = state_reg.ctrl[lpc_pkg::LPC_CB_COPY_DIV2] ? state_reg.samp_half
                                                               : state_reg.samp_clk;
        state_next.copy_clk = copy_base ^ state_reg.ctrl[lpc_pkg::LPC_CB_COPY_INV]; // RULE20
        // synth output taps the unshifted oscillator clock regardless of source
        if (pll_rise) begin
            state_next.syn_half = ~state_reg.syn_half;
        end
        syn_base = state_reg.ctrl[lpc_pkg::LPC_CB_SYN_DIV2] ? state_reg.syn_half
                                                             : state_reg.pll_prev;
        state_next.syn_clk = syn_base ^ state_reg.ctrl[lpc_pkg::LPC_CB_SYN_INV]; // RULE21

        if (!nrst) begin
            state_next            = '0;
            state_next.ctrl       = lpc_pkg::LPC_CTRL_RST;
            state_next.nominal_increment    = lpc_pkg::LPC_NOMINC_RST;
            state_next.line_len   = lpc_pkg::LPC_LINELEN_RST;
            state_next.analog_div = lpc_pkg::LPC_ADIV_RST; // RULE2
            state_next.live_inc   = lpc_pkg::LPC_NOMINC_RST;
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    assign reg_rdata               = state_reg.rdata;
    assign lock_out                = state_reg.lock;
    assign vsync_valid             = state_reg.vvalid;
    assign analog_feedback_divider = state_reg.analog_div;
    assign internal_sample_clock   = state_reg.samp_clk;
    assign output_data_clock       = state_reg.data_clk;
    assign sample_clock_copy_out   = state_reg.copy_clk;
    assign synth_clock_out         = state_reg.syn_clk;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_adiv_write;
        reg_wr && reg_addr == lpc_pkg::LPC_OFS_ADIV;
    endsequence
    sequence s_pll_rise;
        pll_rise && state_reg.ctrl[lpc_pkg::LPC_CB_SYN_DIV2];
    endsequence

    a_adiv_write: assert property (s_adiv_write |=> // RULE2
        analog_feedback_divider == $past(reg_wdata[7:0]))
        else $error("analog divider not updated by write");
    a_inc_off: assert property (state_reg.ctrl[lpc_pkg::LPC_CB_DET_OFF] |=> // RULE13
        state_reg.live_inc == $past(state_reg.nominal_increment))
        else $error("live increment differs from nominal with detector off");
    a_inc_hold: assert property ( // RULE14
        state_reg.fz2 && !state_reg.ctrl[lpc_pkg::LPC_CB_DET_OFF] |=> $stable(state_reg.live_inc))
        else $error("live increment moved while held");
    a_err_hold: assert property (state_reg.fz2 |=> $stable(state_reg.err)) // RULE15
        else $error("error updated while held");
    a_lock_set: assert property (det_take && err_abs <= state_reg.lock_thr |=> lock_out) // RULE10
        else $error("lock not set inside threshold");
    a_gate_min: assert property ($rose(state_reg.hvalid) |-> // RULE7
        !$past(state_reg.ctrl[lpc_pkg::LPC_CB_HGATE_EN]) ||
        $past(state_reg.hcnt) >= $past(state_reg.hgate_len))
        else $error("sync accepted before gate length");
    a_gate_restart: assert property (!h_act ##1 1 |-> // RULE23
        state_reg.hcnt == 8'h00 && !state_reg.hvalid)
        else $error("gate counter not restarted");
    a_line_wrap: assert property ( // RULE5
        pll_rise && state_reg.pix_cnt >= state_reg.line_len - 12'h001 |=>
        state_reg.pix_cnt == 12'h000)
        else $error("line counter did not wrap");
    a_live_read: assert property (reg_rd && reg_addr == lpc_pkg::LPC_OFS_LIVEINC |=> // RULE12
        reg_rdata == $past(state_reg.live_inc))
        else $error("live increment read wrong");
    a_ext_route: assert property (state_reg.ctrl[lpc_pkg::LPC_CB_EXT_SEL] |=> // RULE17
        internal_sample_clock == $past(state_reg.ex2))
        else $error("external clock not routed");
    a_synth_half: assert property (s_pll_rise |=> // RULE21
        state_reg.syn_half != $past(state_reg.syn_half))
        else $error("synth halving did not toggle");
endmodule : lpc_top

// File: lpc_pulse_src.sv
// pulse source standing in for the video sync generator
`timescale 1ns/1ps
module lpc_pulse_src (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // request
    input  wire logic       pol,
    input  wire logic       go,
    input  wire logic [7:0] len,
    // sync pin
    output logic            pin
);
    logic [7:0] left_reg;
    always_ff @(posedge clk) begin
        if (!nrst) left_reg <= 8'h00;
        else if (go) left_reg <= len;
        else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
    end
    // idles at the inactive level, so a polarity slip shows up as a stray sync
    assign pin = (left_reg != 8'h00) ? pol : ~pol;
endmodule : lpc_pulse_src

// File: test_line_locked_pixel_clock_pll.sv
// self-checking bench for the line-locked pixel clock generator
`timescale 1ns/1ps
module test_line_locked_pixel_clock_pll;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        hsync_in, vsync_in, hold = 1'b0, ext_clk = 1'b0, ext_run = 1'b0;
    logic        lock_out, vsync_valid, isc, odc, copy_clk, synth_clk;
    logic [7:0]  adiv_out;
    logic        hs_go = 1'b0, vs_go = 1'b0;
    logic [7:0]  hs_len = 8'h00, vs_len = 8'h00;
    logic [3:0]  ext_div = 4'h0;
    int          err_count = 0, n_compared = 0;

    always #2.5 clk = ~clk;
    // slow outside clock, 16 cycles a period, still when unused
    always @(posedge clk) if (ext_run) begin
        ext_div <= ext_div + 4'h1;
        ext_clk <= ext_div[3];
    end

    lpc_top dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_in(hsync_in),
        .vsync_in(vsync_in), .error_hold_pin(hold), .external_sample_clock_in(ext_clk),
        .lock_out(lock_out), .vsync_valid(vsync_valid), .analog_feedback_divider(adiv_out),
        .internal_sample_clock(isc), .output_data_clock(odc),
        .sample_clock_copy_out(copy_clk), .synth_clock_out(synth_clk));
    lpc_pulse_src hs_u (.clk(clk), .nrst(nrst), .pol(1'b1), .go(hs_go), .len(hs_len),
        .pin(hsync_in));
    lpc_pulse_src vs_u (.clk(clk), .nrst(nrst), .pol(1'b1), .go(vs_go), .len(vs_len),
        .pin(vsync_in));

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    // edge counts may be one off since the window phase is arbitrary
    task automatic chk_cnt(input int got, input int exp);
        n_compared++;
        if (got < exp - 1 || got > exp + 1) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_cnt
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic fire(input logic is_v, input logic [7:0] n);
        @(posedge clk);
        if (is_v) begin
            vs_go  <= 1'b1;
            vs_len <= n;
        end else begin
            hs_go  <= 1'b1;
            hs_len <= n;
        end
        @(posedge clk);
        hs_go <= 1'b0;
        vs_go <= 1'b0;
    endtask : fire
    task automatic count_rise(input int sel, input int ncyc, output int n);
        logic prev, cur;
        n = 0;
        prev = 1'b1;
        repeat (ncyc) begin
            @(posedge clk);
            #1;
            case (sel)
                0: cur = synth_clk;
                1: cur = copy_clk;
                2: cur = isc;
                3: cur = odc;
                default: cur = vsync_valid;
            endcase
            if (cur === 1'b1 && prev === 1'b0) n++;
            prev = cur;
        end
    endtask : count_rise

    task automatic test_reset;
        logic [31:0] d;
        rd(lpc_pkg::LPC_OFS_CTRL, d);
        chk32(d, 32'h0000_0002);
        chk32({24'h00_0000, adiv_out}, 32'h0000_0008);
        rd(lpc_pkg::LPC_OFS_LINELEN, d);
        chk32(d, 32'h0000_0320);
        rd(lpc_pkg::LPC_OFS_ADIV, d);
        chk32(d, 32'h0000_0008);
        // read data stands one cycle only, then the port reads zero
        @(posedge clk);
        #1;
        chk32(reg_rdata, 32'h0000_0000);
        wr(lpc_pkg::LPC_OFS_LIVEINC, 32'h0000_0000);
        rd(lpc_pkg::LPC_OFS_LIVEINC, d);
        chk32(d, 32'h2000_0000);
        rd(8'h3C, d);
        chk32(d, 32'h0000_0000);
        // settings past the last step are clipped to step 30
        wr(lpc_pkg::LPC_OFS_PHASE, 32'h0000_001F);
        rd(lpc_pkg::LPC_OFS_PHASE, d);
        chk32(d, 32'h0000_001E);
        // divider eight suits a 14.31818 MHz master clock, under the 120 MHz bound
        wr(lpc_pkg::LPC_OFS_ADIV, 32'h0000_0008);
        $display("reset test done");
    endtask : test_reset

    task automatic test_loop;
        logic [31:0] st, e, live, st2, d;
        wr(lpc_pkg::LPC_OFS_GAINS, 32'h0000_0001);
        wr(lpc_pkg::LPC_OFS_LOCKTHR, 32'h0000_FFFF);
        fire(1'b0, 8'h04);
        repeat (12) @(posedge clk);
        rd(lpc_pkg::LPC_OFS_STATUS, st);
        e = {{16{st[31]}}, st[31:16]};
        live = 32'h2000_0000 + (e <<< 1) + e;
        rd(lpc_pkg::LPC_OFS_LIVEINC, d);
        chk32(d, live);
        chk32({31'h0, lock_out}, 32'h0000_0001);
        @(posedge clk);
        hold <= 1'b1;
        repeat (4) @(posedge clk);
        fire(1'b0, 8'h04);
        repeat (12) @(posedge clk);
        rd(lpc_pkg::LPC_OFS_LIVEINC, d);
        chk32(d, live);
        rd(lpc_pkg::LPC_OFS_STATUS, st2);
        chk32({16'h0, st2[31:16]}, {16'h0, st[31:16]});
        @(posedge clk);
        hold <= 1'b0;
        wr(lpc_pkg::LPC_OFS_CTRL, 32'h0000_0003);
        wr(lpc_pkg::LPC_OFS_NOMINC, 32'h1800_0000);
        repeat (3) @(posedge clk);
        rd(lpc_pkg::LPC_OFS_LIVEINC, d);
        chk32(d, 32'h1800_0000);
        chk32({31'h0, lock_out}, 32'h0000_0000);
        wr(lpc_pkg::LPC_OFS_NOMINC, 32'h2000_0000);
        $display("loop test done");
    endtask : test_loop

    task automatic test_gate;
        int n;
        wr(lpc_pkg::LPC_OFS_GATES, 32'h0000_0A0A);
        wr(lpc_pkg::LPC_OFS_CTRL, 32'h0000_0603);
        // short then long hsync under the gate, apart so they do not merge
        fire(1'b0, 8'h05);
        repeat (10) @(posedge clk);
        fire(1'b0, 8'h14);
        fire(1'b1, 8'h05);
        count_rise(4, 40, n);
        chk_cnt(n * 2, 0);
        fire(1'b1, 8'h14);
        count_rise(4, 40, n);
        chk_cnt(n * 2, 2);
        // low-active sync: the idle low pin now reads as a standing pulse
        wr(lpc_pkg::LPC_OFS_CTRL, 32'h0000_0001);
        repeat (6) @(posedge clk);
        #1;
        chk32({31'h0, vsync_valid}, 32'h0000_0001);
        wr(lpc_pkg::LPC_OFS_CTRL, 32'h0000_0003);
        fire(1'b1, 8'h03);
        count_rise(4, 40, n);
        chk_cnt(n * 2, 2);
        $display("gate test done");
    endtask : test_gate

    task automatic test_clocks;
        logic [31:0] ctl [12] = '{32'h003, 32'h007, 32'h083, 32'h023, 32'h00B, 32'h00B,
                                  32'h01B, 32'h02B, 32'h00B, 32'h103, 32'h043, 32'h003};
        int sel [12] = '{0, 0, 0, 1, 2, 3, 3, 1, 0, 0, 1, 2};
        int exp [12] = '{20, 10, 10, 10, 10, 10, 5, 5, 20, 20, 20, 20};
        int n;
        ext_run <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            wr(lpc_pkg::LPC_OFS_CTRL, ctl[i]);
            repeat (20) @(posedge clk);
            count_rise(sel[i], 160, n);
            chk_cnt(n, exp[i]);
        end
        ext_run <= 1'b0;
        $display("clock test done");
    endtask : test_clocks

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // guards against a hang anywhere in the sequence
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        test_reset;
        test_loop;
        test_gate;
        test_clocks;
        tally_and_finish;
    end
endmodule : test_line_locked_pixel_clock_pll
